// >>> hlt_consts.svh
`ifndef HLT_CONSTS_SVH
`define HLT_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HLT_OFF_COUNT 8'h00
`define HLT_OFF_PERIOD 8'h04
`define HLT_OFF_CTRL 8'h08
`define HLT_OFF_MODE 8'h0c
`define HLT_OFF_CLKSEL 8'h10
`define HLT_OFF_RSTSEL 8'h14
`define HLT_OFF_IRQ 8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HLT_RST_COUNT 8'h00
`define HLT_RST_PERIOD 8'hff
`define HLT_RST_CTRL 8'h00
`define HLT_RST_MODE 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HLT_CTRL_ON 7
`define HLT_CTRL_CKPS_HI 6
`define HLT_CTRL_CKPS_LO 4
`define HLT_CTRL_POSTSCALE_SELECT_HI 3
`define HLT_CTRL_POSTSCALE_SELECT_LO 0
`define HLT_MODE_CLS_HI 4
`define HLT_MODE_CLS_LO 3
`define HLT_MODE_SUB_HI 2
`define HLT_MODE_SUB_LO 0
`define HLT_MODE_PRESCALE_SYNC_BIT 5
`define HLT_MODE_ENABLE_SYNC_BIT 6
`define HLT_IRQ_FLAG 0
`define HLT_IRQ_EN 1

// ----------------------------------------
// Sizes
// ----------------------------------------
`define HLT_SRC_N 4
`define HLT_DIV_W 7

`endif

// >>> hlt_pkg.sv
package hlt_pkg;
    typedef enum logic [1:0] {HLT_FREE, HLT_ONESHOT, HLT_MONO, HLT_RSVD} hlt_class_e;
    typedef logic [7:0] hlt_byte_t;
    typedef logic [2:0] hlt_ckps_t;
    typedef logic [1:0] hlt_sel_t;
endpackage

// >>> hlt_presc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hlt_presc_if;
    logic clear;
    hlt_pkg::hlt_ckps_t ckps;
    hlt_pkg::hlt_sel_t src_sel;
    logic prescale_sync_bit;
    logic src_tick;
    logic pre_tick;
    modport ctrl (output clear, ckps, src_sel, prescale_sync_bit, input src_tick, pre_tick);
    modport presc (input clear, ckps, src_sel, prescale_sync_bit, output src_tick, pre_tick);
endinterface
`default_nettype wire

// >>> hlt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "hlt_consts.svh"
module hlt_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Clock sources
    input wire logic [`HLT_SRC_N-1:0] src_ticks,
    // Control
    hlt_presc_if.presc pif
);
    import hlt_pkg::*;

    logic [`HLT_DIV_W-1:0] div_ff;
    logic sync_ff;
    logic raw;
    logic hit;
    logic [`HLT_DIV_W-1:0] mask;

    // ----------------------------------------
    // Source select and divider
    // ----------------------------------------
    assign raw = src_ticks[pif.src_sel];
    assign mask = `HLT_DIV_W'((8'h01 << pif.ckps) - 8'h01);
    assign hit = raw && ((div_ff & mask) == mask);

    always_ff @(posedge clk) begin
        if (sys_rst || pif.clear) begin
            div_ff <= '0;
        end else if (raw) begin
            div_ff <= `HLT_DIV_W'(div_ff + 1'b1);
        end
    end

    // ----------------------------------------
    // Optional output resync
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || pif.clear) begin
            sync_ff <= 1'b0;
        end else begin
            sync_ff <= hit;
        end
    end

    assign pif.src_tick = raw;
    assign pif.pre_tick = pif.prescale_sync_bit ? sync_ff : hit;

    chk_div_one_pass: assert property (@(posedge clk) disable iff (sys_rst)
        (pif.ckps == 3'h0 && !pif.prescale_sync_bit && raw) |-> pif.pre_tick)
        else $error("divide by one lost a tick");
    chk_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
        (pif.prescale_sync_bit && $stable(pif.prescale_sync_bit) && hit && !pif.clear) |=> pif.pre_tick)
        else $error("resynced tick not one cycle late");
endmodule
`default_nettype wire

// >>> hlt_timer.sv
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "hlt_consts.svh"
module hlt_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Clock sources and external reset signals
    input wire logic [`HLT_SRC_N-1:0] clk_src_tick,
    input wire logic [`HLT_SRC_N-1:0] external_reset_signal,
    input wire logic debug_mode,
    // Timer outputs
    output logic period_match,
    output logic postscaled_pulse,
    output logic timer_irq
);
    import hlt_pkg::*;

    hlt_presc_if pif ();

    hlt_byte_t count_value_ff;
    hlt_byte_t period_value_ff;
    logic on_ff;
    hlt_ckps_t ckps_ff;
    logic [3:0] postscale_select_ff;
    logic [4:0] mode_ff;
    logic prescale_sync_bit_ff;
    logic enable_sync_bit_ff;
    hlt_sel_t clk_sel_ff;
    hlt_sel_t reset_source_select_ff;
    logic irq_flag_ff;
    logic timer_irq_enable_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic ers_ff;
    logic armed_ff;
    logic on_eff_ff;
    logic [3:0] post_cnt_ff;
    logic match_ff;
    logic pulse_ff;

    hlt_class_e cls;
    logic [2:0] sub;
    logic wr;
    logic rd;
    logic wr_count;
    logic wr_ctrl;
    logic ers_raw;
    logic ers_now;
    logic ers_rise;
    logic ers_fall;
    logic start_evt;
    logic rst_edge;
    logic rst_level;
    logic rst_evt;
    logic gate_ok;
    logic run;
    logic tick;
    logic at_match;
    logic stop_now;
    logic [3:0] postscale_select_eff;
    logic ps_hit;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic edge_pick(input logic [1:0] k, input logic r, input logic f);
        unique case (k)
            2'h1: edge_pick = r;
            2'h2: edge_pick = f;
            2'h3: edge_pick = r | f;
            default: edge_pick = 1'b0;
        endcase
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
        is_addr = (a[7:2] == off[7:2]);
    endfunction

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_count = wr && is_addr(wb_adr_i, `HLT_OFF_COUNT);
    assign wr_ctrl = wr && is_addr(wb_adr_i, `HLT_OFF_CTRL);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0;
        end else if (rd) begin
            rdata_ff <= 32'h0;
            if (is_addr(wb_adr_i, `HLT_OFF_COUNT)) begin
                rdata_ff[7:0] <= count_value_ff;
            end
            if (is_addr(wb_adr_i, `HLT_OFF_PERIOD)) begin
                rdata_ff[7:0] <= period_value_ff;
            end
            if (is_addr(wb_adr_i, `HLT_OFF_CTRL)) begin
                rdata_ff[7:0] <= {on_ff, ckps_ff, postscale_select_ff};
            end
            if (is_addr(wb_adr_i, `HLT_OFF_MODE)) begin
                rdata_ff[7:0] <= {1'b0, enable_sync_bit_ff, prescale_sync_bit_ff, mode_ff};
            end
            if (is_addr(wb_adr_i, `HLT_OFF_CLKSEL)) begin
                rdata_ff[1:0] <= clk_sel_ff;
            end
            if (is_addr(wb_adr_i, `HLT_OFF_RSTSEL)) begin
                rdata_ff[1:0] <= reset_source_select_ff;
            end
            if (is_addr(wb_adr_i, `HLT_OFF_IRQ)) begin
                rdata_ff[1:0] <= {timer_irq_enable_ff, irq_flag_ff};
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_value_ff <= `HLT_RST_PERIOD;
        end else if (wr && is_addr(wb_adr_i, `HLT_OFF_PERIOD)) begin
            period_value_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {ckps_ff, postscale_select_ff} <= 7'h00;
        end else if (wr_ctrl) begin
            ckps_ff <= wb_dat_i[`HLT_CTRL_CKPS_HI:`HLT_CTRL_CKPS_LO];
            postscale_select_ff <= wb_dat_i[`HLT_CTRL_POSTSCALE_SELECT_HI:`HLT_CTRL_POSTSCALE_SELECT_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_ff <= 5'h00;
            prescale_sync_bit_ff <= 1'b0;
            enable_sync_bit_ff <= 1'b0;
            clk_sel_ff <= 2'h0;
            reset_source_select_ff <= 2'h0;
            timer_irq_enable_ff <= 1'b0;
        end else if (wr) begin
            if (is_addr(wb_adr_i, `HLT_OFF_MODE)) begin
                mode_ff <= wb_dat_i[4:0];
                prescale_sync_bit_ff <= wb_dat_i[`HLT_MODE_PRESCALE_SYNC_BIT];
                enable_sync_bit_ff <= wb_dat_i[`HLT_MODE_ENABLE_SYNC_BIT];
            end
            if (is_addr(wb_adr_i, `HLT_OFF_CLKSEL)) begin
                clk_sel_ff <= wb_dat_i[1:0];
            end
            if (is_addr(wb_adr_i, `HLT_OFF_RSTSEL)) begin
                reset_source_select_ff <= wb_dat_i[1:0];
            end
            if (is_addr(wb_adr_i, `HLT_OFF_IRQ)) begin
                timer_irq_enable_ff <= wb_dat_i[`HLT_IRQ_EN];
            end
        end
    end

    // ----------------------------------------
    // External reset source and modes
    // ----------------------------------------
    assign cls = hlt_class_e'(mode_ff[`HLT_MODE_CLS_HI:`HLT_MODE_CLS_LO]);
    assign sub = mode_ff[`HLT_MODE_SUB_HI:`HLT_MODE_SUB_LO];
    assign ers_raw = external_reset_signal[reset_source_select_ff];
    assign ers_now = debug_mode ? ers_ff : ers_raw;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ers_ff <= 1'b0;
        end else begin
            ers_ff <= ers_now;
        end
    end

    assign ers_rise = ers_now && !ers_ff;
    assign ers_fall = !ers_now && ers_ff;

    always_comb begin
        start_evt = 1'b0;
        rst_edge = 1'b0;
        rst_level = 1'b0;
        gate_ok = 1'b1;
        unique case (cls)
            HLT_FREE: begin
                if (sub == 3'h1) gate_ok = ers_now;
                if (sub == 3'h2) gate_ok = !ers_now;
                if (sub == 3'h3) rst_edge = ers_rise | ers_fall;
                if (sub == 3'h4) rst_edge = ers_rise;
                if (sub == 3'h5) rst_edge = ers_fall;
                if (sub == 3'h6) rst_level = !ers_now;
                if (sub == 3'h7) rst_level = ers_now;
            end
            HLT_ONESHOT: begin
                start_evt = (sub == 3'h0) ? 1'b1 :
                    edge_pick((sub == 3'h3) ? 2'h3 : {~(sub[0] ^ sub[2]), sub[0] ^ sub[2]},
                        ers_rise, ers_fall);
                if (sub == 3'h4) rst_edge = ers_rise;
                if (sub == 3'h5) rst_edge = ers_fall;
                if (sub == 3'h6) rst_level = !ers_now;
                if (sub == 3'h7) rst_level = ers_now;
            end
            HLT_MONO: begin
                start_evt = edge_pick(sub[1:0], ers_rise, ers_fall) & ~sub[2];
                if (sub == 3'h6) start_evt = ers_now;
                if (sub == 3'h7) start_evt = !ers_now;
                if (sub == 3'h6) rst_level = !ers_now;
                if (sub == 3'h7) rst_level = ers_now;
            end
            HLT_RSVD: begin
                gate_ok = 1'b0;
            end
        endcase
    end

    assign rst_evt = rst_edge || rst_level;

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    assign at_match = (count_value_ff == period_value_ff);
    assign tick = run && pif.pre_tick;
    assign stop_now = tick && at_match && (cls != HLT_FREE);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            on_ff <= 1'b0;
        end else if (wr_ctrl) begin
            on_ff <= wb_dat_i[`HLT_CTRL_ON];
        end else if (stop_now && (cls == HLT_ONESHOT || sub[2:1] == 2'h3)) begin
            on_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !on_ff) begin
            armed_ff <= (cls == HLT_FREE) ? 1'b1 : 1'b0;
        end else if (cls == HLT_FREE) begin
            armed_ff <= 1'b1;
        end else if (stop_now) begin
            armed_ff <= 1'b0;
        end else if (start_evt) begin
            armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            on_eff_ff <= 1'b0;
        end else if (!enable_sync_bit_ff || pif.src_tick) begin
            on_eff_ff <= on_ff;
        end
    end

    // Direct path when enable sync is off
    assign run = (enable_sync_bit_ff ? on_eff_ff : on_ff) && on_ff
        && gate_ok && armed_ff && !rst_level;

    // ----------------------------------------
    // Count and prescaler
    // ----------------------------------------
    assign pif.clear = wr_count || wr_ctrl || rst_evt;
    assign pif.ckps = ckps_ff;
    assign pif.src_sel = clk_sel_ff;
    assign pif.prescale_sync_bit = prescale_sync_bit_ff;

    hlt_prescaler u_presc (
        .clk(clk),
        .sys_rst(sys_rst),
        .src_ticks(clk_src_tick),
        .pif(pif)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_value_ff <= `HLT_RST_COUNT;
        end else if (wr_count) begin
            count_value_ff <= wb_dat_i[7:0];
        end else if (rst_evt) begin
            count_value_ff <= 8'h00;
        end else if (tick) begin
            count_value_ff <= at_match ? 8'h00 : 8'(count_value_ff + 1'b1);
        end
    end

    // ----------------------------------------
    // Match and postscaler
    // ----------------------------------------
    assign postscale_select_eff = (cls == HLT_ONESHOT) ? 4'h0 : postscale_select_ff;
    assign ps_hit = tick && at_match && (post_cnt_ff == postscale_select_eff);

    always_ff @(posedge clk) begin
        if (sys_rst || pif.clear) begin
            post_cnt_ff <= 4'h0;
        end else if (tick && at_match) begin
            post_cnt_ff <= ps_hit ? 4'h0 : 4'(post_cnt_ff + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            match_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            match_ff <= at_match;
            pulse_ff <= ps_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_flag_ff <= 1'b0;
        end else if (pulse_ff) begin
            irq_flag_ff <= 1'b1;
        end else if (wr && is_addr(wb_adr_i, `HLT_OFF_IRQ) && wb_dat_i[`HLT_IRQ_FLAG]) begin
            irq_flag_ff <= 1'b0;
        end
    end

    assign period_match = match_ff;
    assign postscaled_pulse = pulse_ff;
    assign timer_irq = irq_flag_ff && timer_irq_enable_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_count_step: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && !at_match && !wr_count && !rst_evt) |=>
        count_value_ff == 8'($past(count_value_ff) + 1'b1))
        else $error("count did not step on tick");
    chk_match_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && at_match && !wr_count) |=> count_value_ff == 8'h00 ##0 period_match)
        else $error("match did not clear count");
    chk_reset_vals: assert property (@(posedge clk)
        sys_rst |=> count_value_ff == 8'h00 && period_value_ff == 8'hff)
        else $error("reset values wrong");
    chk_ctrl_keeps: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_ctrl && !tick && !rst_evt) |=> $stable(count_value_ff))
        else $error("control write moved count");
    chk_post_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_count || wr_ctrl) |=> post_cnt_ff == 4'h0)
        else $error("postscaler not cleared");
    chk_gate_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (cls == HLT_FREE && sub == 3'h1 && !ers_now && !wr_count) |=> $stable(count_value_ff))
        else $error("count moved with gate closed");
    chk_oneshot_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (cls == HLT_ONESHOT && tick && at_match && !wr_ctrl) |=> !on_ff)
        else $error("one-shot did not stop");
    chk_irq_delay: assert property (@(posedge clk) disable iff (sys_rst)
        ps_hit |-> ##[1:2] irq_flag_ff)
        else $error("flag late after postscale match");
    chk_pulse_width: assert property (@(posedge clk) disable iff (sys_rst)
        postscaled_pulse |=> !postscaled_pulse || $past(ps_hit))
        else $error("pulse too wide");
    chk_debug_freeze: assert property (@(posedge clk) disable iff (sys_rst)
        debug_mode |-> !ers_rise && !ers_fall)
        else $error("trigger seen in debug mode");
    chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        pulse_ff |=> irq_flag_ff)
        else $error("flag not set after pulse");
endmodule
`default_nettype wire

// >>> hlt_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module hlt_src_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Requested trigger levels
    input wire logic [3:0] ers_req,
    // Sources toward the timer
    output logic [3:0] clk_src_tick,
    output logic [3:0] external_reset_signal
);
    logic half_ff;
    logic [3:0] ers_ff;
    // ----------------------------------------
    // Tick sources and trigger levels
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            half_ff <= 1'b0;
            ers_ff <= 4'h0;
        end else begin
            half_ff <= ~half_ff;
            ers_ff <= ers_req;
        end
    end
    assign clk_src_tick = {2'b00, half_ff, 1'b1};
    assign external_reset_signal = ers_ff;
endmodule
`default_nettype wire

// >>> hlt_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module hlt_timer_tb;
    logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack, pm, pp, irq;
    logic [3:0] ticks, ers, ers_req = 4'h0;
    logic [7:0] q;
    int errors = 0, samples_checked = 0, cyc_n = 0, t0, k;
    // ----------------------------------------
    // Design and source model
    // ----------------------------------------
    hlt_timer dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .clk_src_tick(ticks), .external_reset_signal(ers),
        .debug_mode(dbg), .period_match(pm), .postscaled_pulse(pp), .timer_irq(irq));
    hlt_src_model src (.clk(clk), .sys_rst(sys_rst), .ers_req(ers_req),
        .clk_src_tick(ticks), .external_reset_signal(ers));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            errors++;
            results();
        end
    end
    // ----------------------------------------
    // Bus cycles and checks
    // ----------------------------------------
    task automatic results();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) chk(8'h00, 8'h01);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb(a, 1'b0, 8'h00);
        chk(q, exp);
    endtask
    task automatic wait_pp(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pp !== 1'b1 && n < lim);
        if (n >= lim) chk(8'h00, 8'h02);
    endtask
    task automatic gap(input logic [7:0] ctrl, input int exp);
        wb(8'h08, 1'b1, ctrl);
        wait_pp(exp + 20);
        t0 = cyc_n;
        wait_pp(exp + 2);
        chk(8'(cyc_n - t0), 8'(exp));
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h04, 8'hff);
        rd(8'h08, 8'h00);
        rd(8'h0c, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h40, 8'h00);
        wb(8'h04, 1'b1, 8'ha5);
        rd(8'h04, 8'ha5);
        wb(8'h00, 1'b1, 8'h3c);
        rd(8'h00, 8'h3c);
        wb(8'h00, 1'b1, 8'h00);
        wb(8'h04, 1'b1, 8'h02);
        for (k = 0; k < 8; k++) gap(8'h80 | 8'(k << 4), 3 << k);
        for (k = 0; k < 16; k++) gap(8'h80 | 8'(k), 3 * (k + 1));
        wb(8'h10, 1'b1, 8'h01);
        gap(8'h80, 6);
        wb(8'h10, 1'b1, 8'h00);
        wb(8'h08, 1'b1, 8'h00);
        wb(8'h0c, 1'b1, 8'h60);
        gap(8'h90, 6);
        wb(8'h08, 1'b1, 8'h00);
        wb(8'h0c, 1'b1, 8'h00);
        rd(8'h18, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wb(8'h18, 1'b1, 8'h02);
        @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wb(8'h18, 1'b1, 8'h03);
        rd(8'h18, 8'h02);
        wb(8'h00, 1'b1, 8'h5a);
        wb(8'h08, 1'b1, 8'h30);
        rd(8'h00, 8'h5a);
        wb(8'h00, 1'b1, 8'h00);
        wb(8'h04, 1'b1, 8'h03);
        wb(8'h0c, 1'b1, 8'h08);
        wb(8'h08, 1'b1, 8'h85);
        wait_pp(12);
        repeat (3) @(posedge clk);
        rd(8'h08, 8'h05);
        wb(8'h04, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h0, pm}, 8'h01);
        wb(8'h14, 1'b1, 8'h02);
        wb(8'h04, 1'b1, 8'hff);
        wb(8'h0c, 1'b1, 8'h01);
        wb(8'h00, 1'b1, 8'h10);
        wb(8'h08, 1'b1, 8'h80);
        repeat (8) @(posedge clk);
        rd(8'h00, 8'h10);
        ers_req <= 4'h4;
        repeat (8) @(posedge clk);
        wb(8'h00, 1'b0, 8'h00);
        chk(q, 8'h18);
        wb(8'h0c, 1'b1, 8'h07);
        repeat (8) @(posedge clk);
        rd(8'h00, 8'h00);
        ers_req <= 4'h0;
        repeat (8) @(posedge clk);
        wb(8'h00, 1'b0, 8'h00);
        chk(q, 8'h08);
        dbg <= 1'b1;
        ers_req <= 4'h4;
        repeat (8) @(posedge clk);
        wb(8'h00, 1'b0, 8'h00);
        chk(q, 8'h13);
        results();
    end
endmodule
`default_nettype wire
